// *** src/nss_defs.vh ***
`ifndef NSS_DEFS_VH
`define NSS_DEFS_VH

// symbol geometry
`define NSS_SYM_W 5
`define NSS_BIT_CNT_W 3
`define NSS_BIT_LAST 3'h4
`define NSS_BIT_FIRST 3'h0
`define NSS_MULT 5

// recovered symbol clock is high for bit counts below this value
`define NSS_SYMCLK_HIGH_CNT 3'h2
`define NSS_SYMCLK_FALL_CNT 3'h1

// line level of a forced logical 0 on a differential pair
`define NSS_FORCED_TRUE 1'b0

// timing
`define NSS_CLK_PERIOD_NS 10
`define NSS_SYM_PERIOD_NS 40
`define NSS_SYM_PERIOD_CYC ((`NSS_SYM_PERIOD_NS + `NSS_CLK_PERIOD_NS - 1) / `NSS_CLK_PERIOD_NS)
`define NSS_PERIOD_W 8

`endif

// *** src/nss_edge.v ***
`timescale 1ns/10ps
`default_nettype none

module nss_edge
(
    input wire clk_i,
    input wire arst_n_i,
    input wire sig_i,
    output wire rise_o,
    output wire fall_o
);

    reg last;

    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            last <= 1'b0;
        else
            last <= sig_i;
    end

    assign rise_o = sig_i & ~last;
    assign fall_o = ~sig_i & last;

endmodule

`default_nettype wire

// *** src/nss_nrzi_rx.v ***
`timescale 1ns/10ps
`default_nettype none

module nss_nrzi_rx
#(
    parameter W = 5
)
(
    input wire clk_i,
    input wire arst_n_i,
    input wire bit_tick_i,
    input wire line_i,
    output reg [W-1:0] shift_o,
    output wire [W-1:0] next_shift_o
);

    reg retimed;
    wire nrz_bit;

    // a change of level between two bit samples is a one
    assign nrz_bit = line_i ^ retimed;
    assign next_shift_o = {shift_o[W-2:0], nrz_bit};

    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            retimed <= 1'b0;
            shift_o <= {W{1'b0}};
        end
        else if (bit_tick_i)
        begin
            retimed <= line_i;
            shift_o <= next_shift_o;
        end
    end

endmodule

`default_nettype wire

// *** src/nss_serdes.v ***
// Functional notes
// - transmit bit clock is the local symbol clock rate times five
// - transmit symbol captured on each rising local symbol clock edge
// - captured symbol loaded into shifter at symbol boundary, shifted per bit
// - shifter output converted from NRZ to NRZI before the line pins
// - transmitter off low forces main line pair to logical 0
// - loop output pair forced 0 unless loopback asserted, then mirrors stream
// - receiver retimes serial data on recovered bit clock, then NRZI to NRZ
// - NRZ bits shift into the receive shifter on the recovered bit clock
// - receive output register updates on recovered symbol clock falling edge
// - recovered symbol clock is recovered bit clock divided by five
// - transmit test mode clocks logic from transmitter off pin, ignoring its off role
// - in transmit test mode symbol clock still loads input and resets counter
// - receive test mode clocks logic from loop input pair
// - receive loopback path unavailable in test mode
// - symbol most significant bit goes out first
// - signal detect low locks to local clock and holds output register low
// - loopback asserted selects loop input pair at the receiver
// - signal detect ignored by the receive path while receiver loopback selected; signal_detect_out_o still follows it
`timescale 1ns/10ps
`default_nettype none
`include "nss_defs.vh"

module nss_serdes
#(
    parameter PW = `NSS_PERIOD_W
)
(
    input wire clk_i,
    input wire arst_n_i,
    input wire local_symbol_clock_i,
    input wire [`NSS_SYM_W-1:0] transmit_symbol_in_i,
    input wire transmitter_off_n_i,
    input wire tx_loopback_select_n_i,
    input wire tx_test_i,
    output reg line_out_pair_p_o,
    output reg line_out_pair_n_o,
    output reg loop_out_pair_p_o,
    output reg loop_out_pair_n_o,
    input wire line_in_pair_p_i,
    input wire line_in_pair_n_i,
    input wire loop_in_pair_p_i,
    input wire loop_in_pair_n_i,
    input wire rx_loopback_select_n_i,
    input wire rx_test_i,
    input wire signal_detect_in_i,
    output reg signal_detect_out_o,
    output reg recovered_symbol_clock_o,
    output reg [`NSS_SYM_W-1:0] receive_symbol_out_o
);

    localparam [PW-1:0] SYM_PERIOD_RST = `NSS_SYM_PERIOD_CYC;
    localparam [PW:0] MULT = `NSS_MULT;
    localparam [PW-1:0] PER_MAX = {PW{1'b1}};

    // reference period measurement
    wire sym_rise;
    reg [PW-1:0] per_cnt;
    reg [PW-1:0] sym_period;

    nss_edge u_sym_edge
    (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .sig_i(local_symbol_clock_i), .rise_o(sym_rise), .fall_o()
    );

    // the multiplier measures the reference and rebuilds five ticks per period
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            per_cnt <= {PW{1'b0}};
            sym_period <= SYM_PERIOD_RST;
        end
        else if (sym_rise)
        begin
            per_cnt <= {{(PW-1){1'b0}}, 1'b1};
            if (per_cnt != {PW{1'b0}})
                sym_period <= per_cnt;
        end
        else if (per_cnt != PER_MAX)
            per_cnt <= per_cnt + {{(PW-1){1'b0}}, 1'b1};
    end

    // transmit bit tick generator
    reg [PW-1:0] tx_acc;
    wire [PW:0] tx_sum;
    wire [PW:0] tx_rem;
    wire tx_nco_tick;
    wire tx_tclk_rise;
    wire tx_bit_tick;

    assign tx_sum = {1'b0, tx_acc} + MULT;
    assign tx_nco_tick = tx_sum >= {1'b0, sym_period};
    assign tx_rem = tx_sum - {1'b0, sym_period};

    nss_edge u_tx_tclk_edge
    (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .sig_i(transmitter_off_n_i), .rise_o(tx_tclk_rise), .fall_o()
    );

    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            tx_acc <= {PW{1'b0}};
        else if (!tx_nco_tick)
            tx_acc <= tx_sum[PW-1:0];
        else if (tx_rem >= {1'b0, sym_period})
            tx_acc <= {PW{1'b0}};
        else
            tx_acc <= tx_rem[PW-1:0];
    end

    assign tx_bit_tick = tx_test_i ? tx_tclk_rise : tx_nco_tick;

    // transmit datapath
    reg [`NSS_SYM_W-1:0] tx_in_reg;
    reg [`NSS_SYM_W-1:0] tx_shift;
    reg [`NSS_BIT_CNT_W-1:0] tx_bit_cnt;
    reg tx_nrzi;
    wire tx_boundary;
    wire next_tx_nrzi;
    wire tx_off_active;
    wire tx_loop_active;

    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            tx_in_reg <= {`NSS_SYM_W{1'b0}};
        else if (sym_rise)
            tx_in_reg <= transmit_symbol_in_i;
    end

    assign tx_boundary = tx_bit_tick && (tx_bit_cnt == `NSS_BIT_LAST);

    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            tx_bit_cnt <= `NSS_BIT_FIRST;
        else if (tx_test_i && sym_rise)
            tx_bit_cnt <= `NSS_BIT_FIRST;
        else if (tx_boundary)
            tx_bit_cnt <= `NSS_BIT_FIRST;
        else if (tx_bit_tick)
            tx_bit_cnt <= tx_bit_cnt + {{(`NSS_BIT_CNT_W-1){1'b0}}, 1'b1};
    end

    // the fifth bit leaves on the same tick that the next symbol loads
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            tx_shift <= {`NSS_SYM_W{1'b0}};
        else if (tx_boundary)
            tx_shift <= tx_in_reg;
        else if (tx_bit_tick)
            tx_shift <= {tx_shift[`NSS_SYM_W-2:0], 1'b0};
    end

    assign next_tx_nrzi = tx_bit_tick ? (tx_nrzi ^ tx_shift[`NSS_SYM_W-1]) : tx_nrzi;

    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            tx_nrzi <= 1'b0;
        else
            tx_nrzi <= next_tx_nrzi;
    end

    // in test mode the off pin is a clock and cannot gate the line
    assign tx_off_active = !tx_test_i && !transmitter_off_n_i;
    assign tx_loop_active = !tx_loopback_select_n_i;

    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            line_out_pair_p_o <= `NSS_FORCED_TRUE;
            line_out_pair_n_o <= ~`NSS_FORCED_TRUE;
            loop_out_pair_p_o <= `NSS_FORCED_TRUE;
            loop_out_pair_n_o <= ~`NSS_FORCED_TRUE;
        end
        else
        begin
            line_out_pair_p_o <= tx_off_active ? `NSS_FORCED_TRUE : next_tx_nrzi;
            line_out_pair_n_o <= tx_off_active ? ~`NSS_FORCED_TRUE : ~next_tx_nrzi;
            loop_out_pair_p_o <= tx_loop_active ? next_tx_nrzi : `NSS_FORCED_TRUE;
            loop_out_pair_n_o <= tx_loop_active ? ~next_tx_nrzi : ~`NSS_FORCED_TRUE;
        end
    end

    // receive source selection
    wire line_level;
    wire loop_level;
    wire rx_loop_active;
    wire rx_data;
    wire rx_data_rise;
    wire rx_data_fall;
    wire rx_tclk_rise;
    wire rx_hold_low;

    // an invalid differential state reads as low
    assign line_level = line_in_pair_p_i & ~line_in_pair_n_i;
    assign loop_level = loop_in_pair_p_i & ~loop_in_pair_n_i;

    // loop pair is the test clock
    assign rx_loop_active = !rx_loopback_select_n_i && !rx_test_i;

    assign rx_data = rx_loop_active ? loop_level : (signal_detect_in_i & line_level);

    assign rx_hold_low = !rx_loop_active && !signal_detect_in_i;

    nss_edge u_rx_data_edge
    (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .sig_i(rx_data), .rise_o(rx_data_rise), .fall_o(rx_data_fall)
    );

    nss_edge u_rx_tclk_edge
    (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .sig_i(loop_level), .rise_o(rx_tclk_rise), .fall_o()
    );

    // receive bit clock recovery
    reg [PW-1:0] rx_acc;
    wire [PW:0] rx_sum;
    wire [PW:0] rx_rem;
    wire rx_nco_tick;
    wire rx_bit_tick;

    assign rx_sum = {1'b0, rx_acc} + MULT;
    assign rx_nco_tick = rx_sum >= {1'b0, sym_period};
    assign rx_rem = rx_sum - {1'b0, sym_period};

    // a data edge re-centres the sample point half a bit away;
    // with no edges the loop free runs on the reference rate
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rx_acc <= {PW{1'b0}};
        else if (rx_data_rise || rx_data_fall)
            rx_acc <= {1'b0, sym_period[PW-1:1]};
        else if (!rx_nco_tick)
            rx_acc <= rx_sum[PW-1:0];
        else if (rx_rem >= {1'b0, sym_period})
            rx_acc <= {PW{1'b0}};
        else
            rx_acc <= rx_rem[PW-1:0];
    end

    assign rx_bit_tick = rx_test_i ? rx_tclk_rise : rx_nco_tick;

    // receive datapath
    wire [`NSS_SYM_W-1:0] rx_next_shift;
    reg [`NSS_SYM_W-1:0] rx_word;
    reg [`NSS_BIT_CNT_W-1:0] rx_bit_cnt;
    wire [`NSS_BIT_CNT_W-1:0] next_rx_bit_cnt;

    nss_nrzi_rx #(.W(`NSS_SYM_W)) u_nrzi_rx
    (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .bit_tick_i(rx_bit_tick), .line_i(rx_data), .shift_o(),
        .next_shift_o(rx_next_shift)
    );

    assign next_rx_bit_cnt = (rx_bit_cnt == `NSS_BIT_LAST) ? `NSS_BIT_FIRST :
                             rx_bit_cnt + {{(`NSS_BIT_CNT_W-1){1'b0}}, 1'b1};

    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rx_bit_cnt <= `NSS_BIT_FIRST;
            recovered_symbol_clock_o <= 1'b1;
        end
        else if (rx_bit_tick)
        begin
            rx_bit_cnt <= next_rx_bit_cnt;
            recovered_symbol_clock_o <= next_rx_bit_cnt < `NSS_SYMCLK_HIGH_CNT;
        end
    end

    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rx_word <= {`NSS_SYM_W{1'b0}};
        else if (rx_bit_tick && (rx_bit_cnt == `NSS_BIT_LAST))
            rx_word <= rx_next_shift;
    end

    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            receive_symbol_out_o <= {`NSS_SYM_W{1'b0}};
        else if (rx_hold_low)
            receive_symbol_out_o <= {`NSS_SYM_W{1'b0}};
        else if (rx_bit_tick && (rx_bit_cnt == `NSS_SYMCLK_FALL_CNT))
            receive_symbol_out_o <= rx_word;
    end

    // signal detect retimed by the reference
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            signal_detect_out_o <= 1'b0;
        else if (sym_rise)
            signal_detect_out_o <= signal_detect_in_i;
    end

endmodule

`default_nettype wire

// *** tb/nss_serdes_chk_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "nss_defs.vh"
module nss_serdes_chk
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic transmitter_off_n_i,
    input wire logic tx_loopback_select_n_i,
    input wire logic tx_test_i,
    input wire logic line_out_pair_p_o,
    input wire logic line_out_pair_n_o,
    input wire logic loop_out_pair_p_o,
    input wire logic loop_out_pair_n_o,
    input wire logic rx_loopback_select_n_i,
    input wire logic rx_test_i,
    input wire logic signal_detect_in_i,
    input wire logic recovered_symbol_clock_o,
    input wire logic [`NSS_SYM_W-1:0] receive_symbol_out_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_line_off;
        !tx_test_i && !transmitter_off_n_i;
    endsequence
    sequence s_loop_on;
        !tx_loopback_select_n_i && (transmitter_off_n_i || tx_test_i);
    endsequence
    sequence s_rx_gated;
        !signal_detect_in_i && (rx_loopback_select_n_i || rx_test_i);
    endsequence
    a_line_forced_zero: assert property (s_line_off |=> !line_out_pair_p_o && line_out_pair_n_o)
        else $error("line pair not forced to zero");
    a_loop_forced_zero: assert property (tx_loopback_select_n_i |=> !loop_out_pair_p_o && loop_out_pair_n_o)
        else $error("loop pair not forced to zero");
    a_loop_mirrors_line: assert property (s_loop_on |=> loop_out_pair_p_o == line_out_pair_p_o)
        else $error("loop pair differs from line pair");
    a_line_pair_diff: assert property (line_out_pair_p_o != line_out_pair_n_o)
        else $error("line pair not complementary");
    a_loop_pair_diff: assert property (loop_out_pair_p_o != loop_out_pair_n_o)
        else $error("loop pair not complementary");
    a_rx_held_low: assert property (s_rx_gated |=> receive_symbol_out_o == '0)
        else $error("receive word not held low");
    a_rx_word_update: assert property ($changed(receive_symbol_out_o) |->
        $fell(recovered_symbol_clock_o) || receive_symbol_out_o == '0)
        else $error("receive word changed off the symbol clock fall");
    a_test_line_step: assert property (tx_test_i && $past(tx_test_i, 2) && $changed(line_out_pair_p_o)
        |-> $past(transmitter_off_n_i, 1) || $past(transmitter_off_n_i, 2))
        else $error("line moved without a test clock rise");
endmodule
`default_nettype wire

// *** tb/nss_far_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module nss_far_model
#(
    parameter int REF_HALF = 5
)
(
    input wire logic clk_i,
    input wire logic ref_en_i,
    input wire logic lit_i,
    input wire logic lvl_i,
    output var logic ref_clk_o,
    output logic rx_p_o,
    output logic rx_n_o,
    output logic sd_o
);
    int cnt = 0;
    logic junk = 1'b0;
    initial ref_clk_o = 1'b0;
    // reference may be stopped, as a tester would
    always @(posedge clk_i)
    begin
        junk <= ~junk;
        if (ref_en_i)
        begin
            cnt <= (cnt == REF_HALF - 1) ? 0 : cnt + 1;
            if (cnt == REF_HALF - 1)
                ref_clk_o <= ~ref_clk_o;
        end
    end
    // dark fiber shows a changing pattern, not the last level
    assign rx_p_o = lit_i ? lvl_i : junk;
    assign rx_n_o = ~rx_p_o;
    assign sd_o = lit_i;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "nss_defs.vh"
module tb;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [`NSS_SYM_W-1:0] sym = '0;
    logic off_n = 1'b0, tx_lb_n = 1'b1, tx_test = 1'b0, lsc_tst = 1'b0, ref_en = 1'b0;
    logic lit = 1'b0, lvl = 1'b0, rx_lb_n = 1'b1, rx_test = 1'b0, tclk = 1'b0;
    wire logic ref_clk, lop_p, lop_n, lpp, lpn, rxp, rxn, sd, symclk, sd_out;
    wire logic [`NSS_SYM_W-1:0] rsym;
    wire logic lsc = ref_en ? ref_clk : lsc_tst;
    wire logic lin = rx_test ? tclk : lpp;
    int err_total = 0, cmp_count = 0, cycles = 0;

    always #5 clk_i = ~clk_i;

    nss_serdes dut
    (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .local_symbol_clock_i(lsc), .transmit_symbol_in_i(sym),
        .transmitter_off_n_i(off_n), .tx_loopback_select_n_i(tx_lb_n), .tx_test_i(tx_test),
        .line_out_pair_p_o(lop_p), .line_out_pair_n_o(lop_n), .loop_out_pair_p_o(lpp), .loop_out_pair_n_o(lpn),
        .line_in_pair_p_i(rxp), .line_in_pair_n_i(rxn), .loop_in_pair_p_i(lin), .loop_in_pair_n_i(~lin),
        .rx_loopback_select_n_i(rx_lb_n), .rx_test_i(rx_test), .signal_detect_in_i(sd),
        .signal_detect_out_o(sd_out), .recovered_symbol_clock_o(symclk), .receive_symbol_out_o(rsym)
    );
    nss_far_model far (.clk_i(clk_i), .ref_en_i(ref_en), .lit_i(lit), .lvl_i(lvl), .ref_clk_o(ref_clk),
        .rx_p_o(rxp), .rx_n_o(rxn), .sd_o(sd));

    task report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    task check(input string nm, input logic [4:0] seen, input logic [4:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task do_reset();
        arst_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask

    task tick(input logic rx);
        tclk <= rx;
        off_n <= ~rx;
        repeat (4) @(posedge clk_i);
        tclk <= 1'b0;
        off_n <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    // off pin is the bit clock here, so its low phase must not force the line
    task automatic t_tx_test();
        logic [4:0] tab [2] = '{5'h16, 5'h09};
        logic prev;
        tx_test <= 1'b1;
        tx_lb_n <= 1'b0;
        foreach (tab[k])
        begin
            sym <= tab[k];
            lsc_tst <= 1'b1;
            repeat (3) @(posedge clk_i);
            lsc_tst <= 1'b0;
            repeat (3) @(posedge clk_i);
            repeat (5) tick(1'b0);
            prev = lop_p;
            for (int i = 4; i >= 0; i--)
            begin
                tick(1'b0);
                check("tx bit", 5'(lop_p ^ prev), 5'(tab[k][i]));
                check("tx pair", {4'h0, lop_n}, {4'h0, ~lop_p});
                prev = lop_p;
            end
        end
        tx_test <= 1'b0;
    endtask

    // loopback select set on purpose: test mode must still read the line pair
    task automatic t_rx_test();
        logic l = 1'b0;
        logic [6:0] bits = {5'h19, 2'b00};
        rx_test <= 1'b1;
        rx_lb_n <= 1'b0;
        lit <= 1'b1;
        do_reset();
        for (int i = 6; i >= 0; i--)
        begin
            l = l ^ bits[i];
            lvl <= l;
            repeat (3) @(posedge clk_i);
            tick(1'b1);
            if (i == 1)
            begin
                check("rx early word", rsym, 5'h00);
                check("symclk high", 5'(symclk), 5'h01);
            end
        end
        check("rx word", rsym, 5'h19);
        check("symclk low", 5'(symclk), 5'h00);
    endtask

    task automatic t_loop();
        int tog = 0;
        logic last;
        rx_test <= 1'b0;
        lit <= 1'b0;
        ref_en <= 1'b1;
        sym <= 5'h1F;
        tx_lb_n <= 1'b0;
        repeat (200) @(posedge clk_i);
        #1;
        last = lpp;
        repeat (20)
        begin
            @(posedge clk_i);
            #1;
            check("line off", {3'b0, lop_p, lop_n}, 5'h01);
            tog += (lpp !== last);
            last = lpp;
        end
        // back onto the edge so later stimulus lands at a rising edge
        @(posedge clk_i);
        check("loop runs", 5'(tog != 0), 5'h01);
        check("bit rate", 5'(tog), 5'h0a);
        check("loop rx word", rsym, 5'h1F);
        check("sd out low", {4'h0, sd_out}, 5'h00);
        lit <= 1'b1;
        repeat (12) @(posedge clk_i);
        check("sd out high", {4'h0, sd_out}, 5'h01);
        lit <= 1'b0;
        rx_lb_n <= 1'b1;
        tx_lb_n <= 1'b1;
        repeat (5) @(posedge clk_i);
        check("loop off", {3'b0, lpp, lpn}, 5'h01);
        check("rx held", rsym, 5'h00);
    endtask

    initial
    begin
        do_reset();
        t_tx_test();
        t_rx_test();
        t_loop();
        report_and_stop();
    end
endmodule

bind nss_serdes nss_serdes_chk u_chk
(
    .clk_i(clk_i), .arst_n_i(arst_n_i), .transmitter_off_n_i(transmitter_off_n_i),
    .tx_loopback_select_n_i(tx_loopback_select_n_i), .tx_test_i(tx_test_i),
    .line_out_pair_p_o(line_out_pair_p_o), .line_out_pair_n_o(line_out_pair_n_o),
    .loop_out_pair_p_o(loop_out_pair_p_o), .loop_out_pair_n_o(loop_out_pair_n_o),
    .rx_loopback_select_n_i(rx_loopback_select_n_i), .rx_test_i(rx_test_i),
    .signal_detect_in_i(signal_detect_in_i), .recovered_symbol_clock_o(recovered_symbol_clock_o),
    .receive_symbol_out_o(receive_symbol_out_o)
);
`default_nettype wire
